// File: bench/rcs_ctrl_monitor.sv
`timescale 1ns/1ns
module rcs_ctrl_monitor import rcs_pkg::*; #(
  parameter bit TRIM_SUPPORTED = 1'b1,
  parameter int NUM_CHANNELS = 6
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire rcs_pkg::rcs_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // Analog side.
  input wire rcs_pkg::rcs_conv_phase_t conv_phase,
  input wire logic [NUM_CHANNELS-1:0] timer_channel_output,
  input wire rcs_pkg::rcs_ref_out_t ref_out,
  input wire rcs_pkg::rcs_cur_out_t cur_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cur_wr;
    sfr_req.wr && sfr_req.addr == 8'hb9 && sfr_req.page == 4'h0 ##1 1'b1;
  endsequence
  sequence s_ref_wr;
    sfr_req.wr && sfr_req.addr == 8'hd1 && sfr_req.page == 4'h0 ##1 1'b1;
  endsequence
  sequence s_ref_rd;
    sfr_req.rd && sfr_req.addr == 8'hd1 && sfr_req.page == 4'h0;
  endsequence
  AST_ACTIVE: assert property (
    cur_out.active == (cur_out.current_step_count != 6'h00))
    else $error("active flag disagrees with step count");
  AST_UA: assert property (
    cur_out.current_ua == (cur_out.current_range_select ?
      {cur_out.current_step_count, 3'h0} : {3'h0, cur_out.current_step_count}))
    else $error("current magnitude wrong");
  AST_CUR_WR: assert property (s_cur_wr |=>
    cur_out.current_step_count == $past(sfr_req.wdata[5:0], 2)
    && cur_out.sink == $past(sfr_req.wdata[7], 2))
    else $error("current write not applied");
  AST_REF_GND: assert property (s_ref_wr |=>
    ref_out.analog_ground_select == $past(sfr_req.wdata[5], 2))
    else $error("ground select write not applied");
  AST_REF_SEL: assert property (s_ref_wr |=>
    ref_out.voltage_source_select == $past(sfr_req.wdata[4:3], 2))
    else $error("reference select write not applied");
  AST_RD_UNUSED: assert property (s_ref_rd |=>
    sfr_rdata[7:6] == 2'b00 && !sfr_rdata[1])
    else $error("unused reference bits read nonzero");
  AST_GND: assert property ($past(rst_n) |->
    ref_out.use_analog_ground == (ref_out.analog_ground_select &&
    ($past(conv_phase.sampling && !conv_phase.temp_channel) ||
    ($past(conv_phase.converting) &&
    ref_out.voltage_source_select != RCS_VREF_FAST))))
    else $error("ground reference choice wrong");
  AST_TRIM: assert property (
    cur_out.trim_gate |-> $past(|timer_channel_output))
    else $error("trim gate on without channel output");
endmodule
bind rcs_ref_current_ctrl rcs_ctrl_monitor #(
  .TRIM_SUPPORTED(TRIM_SUPPORTED), .NUM_CHANNELS(NUM_CHANNELS)) u_mon (
  .core_clk(core_clk), .rst_n(rst_n), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .conv_phase(conv_phase),
  .timer_channel_output(timer_channel_output),
  .ref_out(ref_out), .cur_out(cur_out));

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import rcs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  rcs_sfr_req_t req = '0;
  rcs_conv_phase_t ph = '0;
  logic [5:0] chan = 6'h00;
  logic [7:0] rdata;
  rcs_ref_out_t ref_o;
  rcs_cur_out_t cur_o;
  int num_errors = 0;
  int num_checks = 0;
  always #4 core_clk = ~core_clk;
  rcs_ref_current_ctrl uut (.core_clk(core_clk), .rst_n(rst_n),
    .sfr_req(req), .sfr_rdata(rdata), .conv_phase(ph),
    .timer_channel_output(chan), .ref_out(ref_o), .cur_out(cur_o));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, p, d);
    req = '{a, p[3:0], 1'b1, 1'b0, d};
    @(negedge core_clk);
    req = '0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, p, e);
    req = '{a, p[3:0], 1'b0, 1'b1, 8'h00};
    @(negedge core_clk);
    req = '0;
    @(negedge core_clk);
    chk(rdata, e);
  endtask
  task automatic ph_chk(input logic [2:0] p, input logic e);
    ph = p;
    repeat (2) @(negedge core_clk);
    chk(ref_o.use_analog_ground, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Register and output scenarios.
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    rd(8'hb9, 8'h0, 8'h00);
    rd(8'hb9, 8'hf, 8'h00);
    rd(8'hd1, 8'h0, 8'h18);
    rd(8'h80, 8'h0, 8'h00);
    wr(8'hd1, 8'h0, 8'hff);
    rd(8'hd1, 8'h0, 8'h3d);
    chk(ref_o.thermal_sensor_enable, 1'b1);
    chk(ref_o.precision_ref_output_enable, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(8'hd1, 8'h0, {3'b001, i[1:0], 3'b000});
      chk(ref_o.voltage_source_select, i[1:0]);
      ph_chk(3'b100, 1'b1);
      ph_chk(3'b101, 1'b0);
      ph_chk(3'b010, i != 3);
    end
    wr(8'hd1, 8'h0, 8'h00);
    chk(ref_o.thermal_sensor_enable, 1'b0);
    chk(ref_o.precision_ref_output_enable, 1'b0);
    ph_chk(3'b110, 1'b0);
    wr(8'hb9, 8'h0, 8'hc5);
    chk(cur_o.current_ua, 9'd40);
    chk({cur_o.sink, cur_o.current_range_select, cur_o.active}, 3'h7);
    wr(8'hb9, 8'h0, 8'h3f);
    chk({cur_o.sink, cur_o.current_ua}, 10'h03f);
    wr(8'hb9, 8'h0, 8'h00);
    chk(cur_o.active, 1'b0);
    wr(8'hb9, 8'hf, 8'hff);
    rd(8'hb9, 8'hf, 8'h87);
    rd(8'hb9, 8'h0, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(8'hb9, 8'hf, {5'b10000, s[2:0]});
      chan = 6'h01 << s;
      repeat (2) @(negedge core_clk);
      chk(cur_o.trim_gate, s < 6);
      chan = ~(6'h01 << s);
      repeat (2) @(negedge core_clk);
      chk(cur_o.trim_gate, 1'b0);
    end
    wr(8'hb9, 8'hf, 8'h05);
    chan = 6'h3f;
    repeat (2) @(negedge core_clk);
    chk(cur_o.trim_gate, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    rd(8'hd1, 8'h0, 8'h18);
    rd(8'hb9, 8'hf, 8'h00);
    chk(cur_o.trim_gate, 1'b0);
    print_verdict();
  end
endmodule

// File: core/rcs_cfg.svh
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
// Notes on behaviour
// R01: Ground select 1 uses analog ground pin.
// R02: Analog ground applies in sampling and conversion.
// R03: Temperature sensor sampling always uses chip ground; code uses analog ground if also converting without high-speed reference.
// R04: High-speed reference forces chip ground converting; code uses analog ground if sampling of a non-temperature channel is also set.
// R05: Reference select: pin, supply, digital, high-speed.
// R06: Sensor disabled means high-impedance sensor output.
// R07: Output enable powers and connects precision reference.
// R08: Upper two reference bits read zero.
// R09: Direction bit zero sources, one sinks.
// R10: Range bit picks 1 uA or 8 uA steps.
// R11: Current equals direction times step times count.
// R12: Nonzero count activates; all zeros disables.
// R13: Fine trim gates extra two-LSB source.
// R14: Full trim equals low bits set 10.
// R15: Trim source codes 000-101 select channels.
// R16: Bit 7 enables fine trim where supported.
// R17: Trim configuration bits 6-3 read zero.
// R18: Reserved trim source keeps trim gate off.

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RCS_ADDR_CUR_CTRL 8'hb9
`define RCS_ADDR_TRIM_CFG 8'hb9
`define RCS_ADDR_REF_CTRL 8'hd1
`define RCS_PAGE_CUR_CTRL 4'h0
`define RCS_PAGE_TRIM_CFG 4'hf
`define RCS_PAGE_REF_CTRL 4'h0
`define RCS_RST_CUR_CTRL 8'h00
`define RCS_RST_TRIM_CFG 8'h00
`define RCS_RST_REF_CTRL 8'h18

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define RCS_REF_GND_BIT 5
`define RCS_REF_SEL_HI 4
`define RCS_REF_SEL_LO 3
`define RCS_REF_TEMP_BIT 2
`define RCS_REF_OE_BIT 0
`define RCS_REF_WMASK 8'h3d
`define RCS_CUR_DIR_BIT 7
`define RCS_CUR_RANGE_BIT 6
`define RCS_CUR_CNT_HI 5
`define RCS_TRIM_EN_BIT 7
`define RCS_TRIM_SS_HI 2
`define RCS_TRIM_WMASK 8'h87
`define RCS_TRIM_LAST_SRC 3'h5
`define RCS_STEP_SHIFT_HI 3
`define RCS_CUR_CNT_LO 0
`define RCS_TRIM_SS_LO 0
`define RCS_TRIM_NOEN_MASK 8'h7f
`define RCS_CUR_WMASK 8'hff
`define RCS_RDATA_IDLE 8'h00
`define RCS_CNT_ZERO 6'h00
`define RCS_REG_W 8
`endif

// File: core/rcs_pkg.sv
package rcs_pkg;

  typedef enum logic [1:0] {
    RCS_VREF_PIN,
    RCS_VREF_SUPPLY,
    RCS_VREF_DIGITAL,
    RCS_VREF_FAST
  } rcs_vref_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] page;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rcs_sfr_req_t;

  typedef struct packed {
    logic sampling;
    logic converting;
    logic temp_channel;
  } rcs_conv_phase_t;

  typedef struct packed {
    logic analog_ground_select;
    rcs_vref_t voltage_source_select;
    logic thermal_sensor_enable;
    logic precision_ref_output_enable;
    logic use_analog_ground;
  } rcs_ref_out_t;

  typedef struct packed {
    logic sink;
    logic current_range_select;
    logic [5:0] current_step_count;
    logic active;
    logic trim_gate;
    logic [8:0] current_ua;
  } rcs_cur_out_t;

endpackage

// File: core/rcs_ref_current_ctrl.sv
`timescale 1ns/1ns
`include "rcs_cfg.svh"

// ----------------------------------------------------------------
// Masked control register
// ----------------------------------------------------------------
module rcs_masked_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter logic [WIDTH-1:0] WRITE_MASK = '1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Write port.
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  // Stored value.
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (wr_en) begin
      value_next = wdata & WRITE_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= RESET_VAL & WRITE_MASK;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

module rcs_ref_current_ctrl #(
  parameter bit TRIM_SUPPORTED = 1'b1,
  parameter int NUM_CHANNELS = 6
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Special-function register port.
  input wire rcs_pkg::rcs_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Converter phase indications.
  input wire rcs_pkg::rcs_conv_phase_t conv_phase,
  // Timer array channel outputs.
  input wire logic [NUM_CHANNELS-1:0] timer_channel_output,
  // Analog controls.
  output rcs_pkg::rcs_ref_out_t ref_out,
  output rcs_pkg::rcs_cur_out_t cur_out
);
  import rcs_pkg::*;

  localparam logic [7:0] TRIM_MASK = TRIM_SUPPORTED ? `RCS_TRIM_WMASK :
                                     (`RCS_TRIM_WMASK & `RCS_TRIM_NOEN_MASK);

  logic [7:0] ref_ctrl_reg;
  logic [7:0] cur_ctrl_reg;
  logic [7:0] trim_cfg_reg;
  logic hit_ref;
  logic hit_cur;
  logic hit_trim;
  logic wr_ref;
  logic wr_cur;
  logic wr_trim;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  rcs_vref_t vref_sel;
  logic use_agnd_next;
  logic gnd_sel_reg;
  rcs_vref_t vref_sel_reg;
  logic temp_en_reg;
  logic prec_oe_reg;
  logic use_agnd_reg;
  logic [2:0] trim_src;
  logic trim_src_legal;
  logic [5:0] step_count;
  logic trim_next;
  logic active_next;
  logic [8:0] ua_next;
  logic sink_reg;
  logic range_reg;
  logic [5:0] step_count_reg;
  logic active_reg;
  logic trim_gate_reg;
  logic [8:0] ua_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign hit_ref = sfr_req.addr == `RCS_ADDR_REF_CTRL &&
                   sfr_req.page == `RCS_PAGE_REF_CTRL;
  assign hit_cur = sfr_req.addr == `RCS_ADDR_CUR_CTRL &&
                   sfr_req.page == `RCS_PAGE_CUR_CTRL;
  assign hit_trim = sfr_req.addr == `RCS_ADDR_TRIM_CFG &&
                    sfr_req.page == `RCS_PAGE_TRIM_CFG;
  assign wr_ref = sfr_req.wr && hit_ref;
  assign wr_cur = sfr_req.wr && hit_cur;
  assign wr_trim = sfr_req.wr && hit_trim;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  rcs_masked_reg #(
    .WIDTH(`RCS_REG_W),
    .RESET_VAL(`RCS_RST_REF_CTRL),
    .WRITE_MASK(`RCS_REF_WMASK) // R08
  ) u_ref_ctrl (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_ref),
    .wdata(sfr_req.wdata),
    .value(ref_ctrl_reg)
  );

  rcs_masked_reg #(
    .WIDTH(`RCS_REG_W),
    .RESET_VAL(`RCS_RST_CUR_CTRL),
    .WRITE_MASK(`RCS_CUR_WMASK) // R12
  ) u_cur_ctrl (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_cur),
    .wdata(sfr_req.wdata),
    .value(cur_ctrl_reg)
  );

  rcs_masked_reg #(
    .WIDTH(`RCS_REG_W),
    .RESET_VAL(`RCS_RST_TRIM_CFG),
    .WRITE_MASK(TRIM_MASK) // R16 R17
  ) u_trim_cfg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_trim),
    .wdata(sfr_req.wdata),
    .value(trim_cfg_reg)
  );

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_req.rd) begin
      rdata_next = `RCS_RDATA_IDLE;
      if (hit_ref) begin
        rdata_next = ref_ctrl_reg; // R08
      end else if (hit_cur) begin
        rdata_next = cur_ctrl_reg;
      end else if (hit_trim) begin
        rdata_next = trim_cfg_reg; // R17
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `RCS_RDATA_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Ground and voltage reference routing
  // ----------------------------------------------------------------
  always_comb begin
    use_agnd_next = 1'b0;
    if (ref_ctrl_reg[`RCS_REF_GND_BIT]) begin // R01
      if (conv_phase.sampling && !conv_phase.temp_channel) begin // R02 R03
        use_agnd_next = 1'b1;
      end
      if (conv_phase.converting &&
          rcs_vref_t'(ref_ctrl_reg[`RCS_REF_SEL_HI:`RCS_REF_SEL_LO]) !=
          RCS_VREF_FAST) begin // R02 R04
        use_agnd_next = 1'b1;
      end
    end
  end

  assign vref_sel =
    rcs_vref_t'(ref_ctrl_reg[`RCS_REF_SEL_HI:`RCS_REF_SEL_LO]); // R05

  // ----------------------------------------------------------------
  // Reference output registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gnd_sel_reg <= '0;
    end else begin
      gnd_sel_reg <= ref_ctrl_reg[`RCS_REF_GND_BIT]; // R01
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vref_sel_reg <= RCS_VREF_PIN;
    end else begin
      vref_sel_reg <= vref_sel; // R05
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_en_reg <= '0;
    end else begin
      temp_en_reg <= ref_ctrl_reg[`RCS_REF_TEMP_BIT]; // R06
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prec_oe_reg <= '0;
    end else begin
      prec_oe_reg <= ref_ctrl_reg[`RCS_REF_OE_BIT]; // R07
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      use_agnd_reg <= '0;
    end else begin
      use_agnd_reg <= use_agnd_next; // R01
    end
  end

  // ----------------------------------------------------------------
  // Current reference and fine trim
  // ----------------------------------------------------------------
  assign trim_src = trim_cfg_reg[`RCS_TRIM_SS_HI:`RCS_TRIM_SS_LO];
  assign step_count = cur_ctrl_reg[`RCS_CUR_CNT_HI:`RCS_CUR_CNT_LO];
  assign trim_src_legal = trim_src <= `RCS_TRIM_LAST_SRC; // R15 R18

  always_comb begin
    trim_next = 1'b0;
    if (trim_cfg_reg[`RCS_TRIM_EN_BIT] && trim_src_legal) begin // R16
      trim_next = timer_channel_output[trim_src]; // R13 R14
    end
  end

  assign active_next = step_count != `RCS_CNT_ZERO; // R12

  always_comb begin
    ua_next = {`RCS_STEP_SHIFT_HI'(0), step_count};
    if (cur_ctrl_reg[`RCS_CUR_RANGE_BIT]) begin // R10
      ua_next = {step_count, `RCS_STEP_SHIFT_HI'(0)}; // R11
    end
  end

  // ----------------------------------------------------------------
  // Current output registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_reg <= '0;
    end else begin
      sink_reg <= cur_ctrl_reg[`RCS_CUR_DIR_BIT]; // R09
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      range_reg <= '0;
    end else begin
      range_reg <= cur_ctrl_reg[`RCS_CUR_RANGE_BIT]; // R10
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_count_reg <= `RCS_CNT_ZERO;
    end else begin
      step_count_reg <= step_count; // R11
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= '0;
    end else begin
      active_reg <= active_next; // R12
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_gate_reg <= '0;
    end else begin
      trim_gate_reg <= trim_next; // R13
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ua_reg <= '0;
    end else begin
      ua_reg <= ua_next; // R11
    end
  end

  // ----------------------------------------------------------------
  // Output assembly
  // ----------------------------------------------------------------
  assign ref_out = '{
    analog_ground_select: gnd_sel_reg,
    voltage_source_select: vref_sel_reg,
    thermal_sensor_enable: temp_en_reg,
    precision_ref_output_enable: prec_oe_reg,
    use_analog_ground: use_agnd_reg
  };

  assign cur_out = '{
    sink: sink_reg,
    current_range_select: range_reg,
    current_step_count: step_count_reg,
    active: active_reg,
    trim_gate: trim_gate_reg,
    current_ua: ua_reg
  };

endmodule
